// file: verif/hqr_config_regs_tb.sv
/*
  Self-checking bench of the configuration register bank: reset values,
  random writes with read-back, derived outputs, status fields, unmapped
  addresses and clock-enable freeze.
  Assumes the host model sits on the register port.
*/
`timescale 1ns/1ps
module hqr_config_regs_tb;
  import hqr_pkg::*;
  localparam logic [7:0] ADDR_TAB [7] = '{ADDR_EVENT_MASK, ADDR_QUAD_CTRL, ADDR_FILT_A, ADDR_FILT_B,
    ADDR_ROT_SET, ADDR_SCALE_A, ADDR_SCALE_B};
  localparam logic [15:0] RST_TAB [7] = '{16'h001d, 16'h0002, 16'h0205, 16'h0101, 16'h0106, 16'h05e2, 16'h05e2};
  localparam logic [15:0] MASK_TAB [7] = '{16'h001f, 16'h0003, 16'hffff, 16'hffff, 16'h01ef, 16'h3fff, 16'h3fff};
  logic ref_clk, rst, clk_en, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, sys_settings;
  logic [4:0] event_raw, event_out;
  logic [2:0] quad_state;
  logic enc0_level, enc1_level, freewheeling, auto_power, stationary, direction_raw, interval_missed;
  logic [1:0] quad_mode, auto_zero_mode;
  logic quad_enable, quad_open_drain, rotation_interface_enable, discard_missed, keep_missed_report;
  logic force_precise_rate_freewheel, direction, zero_pulse, az_on_stationary, az_continuous, az_on_release;
  logic sensor_enable, freewheel_interface_enable, stream_mode;
  logic [7:0] fast_coeff, slow_coeff, auto_zero_coeff, low_power_coeff;
  logic [4:0] fine_div [2];
  logic [3:0] coarse_mul [2];
  logic [4:0] coarse_div [2];
  logic [15:0] shadow [7];
  integer seed = 32'h440ecc8a;
  int n_fail = 0;
  int check_count = 0;
  int cycle_count = 0;
  int pulse_count = 0;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  hqr_host_model i_hqr_host_model (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  hqr_config_regs #(.NUM_SCALE(2)) i_hqr_config_regs (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sys_settings(sys_settings), .event_raw(event_raw), .quad_state(quad_state),
    .enc0_level(enc0_level), .enc1_level(enc1_level), .freewheeling(freewheeling), .auto_power(auto_power),
    .stationary(stationary), .direction_raw(direction_raw), .interval_missed(interval_missed),
    .event_out(event_out), .quad_mode(quad_mode), .quad_enable(quad_enable), .quad_open_drain(quad_open_drain),
    .fast_coeff(fast_coeff), .slow_coeff(slow_coeff), .auto_zero_coeff(auto_zero_coeff),
    .low_power_coeff(low_power_coeff), .rotation_interface_enable(rotation_interface_enable),
    .discard_missed(discard_missed), .keep_missed_report(keep_missed_report),
    .force_precise_rate_freewheel(force_precise_rate_freewheel), .direction(direction), .zero_pulse(zero_pulse),
    .auto_zero_mode(auto_zero_mode), .az_on_stationary(az_on_stationary), .az_continuous(az_continuous),
    .az_on_release(az_on_release), .sensor_enable(sensor_enable),
    .freewheel_interface_enable(freewheel_interface_enable), .fine_div(fine_div), .coarse_mul(coarse_mul),
    .coarse_div(coarse_div), .stream_mode(stream_mode));

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  function automatic logic [15:0] exp_read(input int k);
    if (k == 1) begin
      return {3'h0, enc1_level, enc0_level, quad_state, 6'h00, shadow[1][1:0]};
    end
    return shadow[k];
  endfunction : exp_read

  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic drive_inputs;
    logic [15:0] r;
    r = 16'($random(seed));
    @(posedge ref_clk);
    sys_settings <= 16'($random(seed));
    event_raw <= r[4:0];
    quad_state <= (r[7:5] > 3'h4) ? 3'h4 : r[7:5];
    {interval_missed, direction_raw, stationary, auto_power, freewheeling, enc1_level, enc0_level} <= r[14:8];
  endtask : drive_inputs

  task automatic check_all;
    logic [15:0] v;
    logic [15:0] q;
    logic [15:0] r;
    q = shadow[1];
    r = shadow[4];
    chk(event_out, sys_settings[13] ? (event_raw & shadow[0][4:0]) : 5'h00);
    chk(stream_mode, !sys_settings[13]);
    chk({quad_mode, quad_enable, quad_open_drain}, {q[1:0], q[1:0] == 2'h1 || q[1:0] == 2'h2, q[1:0] == 2'h1});
    chk({fast_coeff, slow_coeff, auto_zero_coeff, low_power_coeff}, {shadow[2], shadow[3]});
    chk({rotation_interface_enable, sensor_enable, freewheel_interface_enable}, {r[8], r[1], r[0]});
    chk({discard_missed, keep_missed_report}, {r[7], !r[7]} & {2{stationary & interval_missed}});
    chk(force_precise_rate_freewheel, r[6] & freewheeling & auto_power);
    chk(direction, direction_raw ^ r[5]);
    chk({auto_zero_mode, az_on_stationary, az_continuous, az_on_release},
      {r[3:2], r[3:2] == 2'h1, r[3:2] == 2'h2, r[3:2] == 2'h3});
    chk(zero_pulse, 1'b0);
    for (int k = 0; k < 2; k++) begin
      chk({fine_div[k], coarse_mul[k], coarse_div[k]}, shadow[5 + k][13:0]);
    end
    for (int k = 0; k < 7; k++) begin
      i_hqr_host_model.read_word(ADDR_TAB[k], v);
      chk(v, exp_read(k));
    end
  endtask : check_all

  // ************************************************************
  // Watchdog and pulse counter
  // ************************************************************
  always @(posedge ref_clk) begin
    cycle_count++;
    if (zero_pulse === 1'b1) begin
      pulse_count++;
    end
    if (cycle_count == 20000) begin
      n_fail++;
      wrap_up;
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [15:0] d;
    logic [15:0] v;
    int k;
    rst = 1'b1;
    clk_en = 1'b1;
    sys_settings = 16'h0000;
    event_raw = 5'h00;
    quad_state = 3'h0;
    {interval_missed, direction_raw, stationary, auto_power, freewheeling, enc1_level, enc0_level} = 7'h00;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (k = 0; k < 7; k++) begin
      shadow[k] = RST_TAB[k];
    end
    settle;
    check_all;
    for (int it = 0; it < 56; it++) begin
      k = it % 7;
      d = 16'($random(seed));
      if (k == 1 || k == 4) begin
        d[1:0] = 2'((it / 7) % 4);
        d[3:2] = 2'((it / 7) % 4);
      end
      drive_inputs;
      pulse_count = 0;
      i_hqr_host_model.write_word(ADDR_TAB[k], d);
      shadow[k] = d & MASK_TAB[k];
      settle;
      if (k == 4) begin
        chk(pulse_count, {31'h0, d[4]});
      end
      check_all;
    end
    i_hqr_host_model.write_word(8'h68, 16'hffff);
    i_hqr_host_model.read_word(8'h68, v);
    chk(v, 16'h0000);
    i_hqr_host_model.read_word(8'h7b, v);
    chk(v, 16'h0000);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    i_hqr_host_model.write_word(ADDR_FILT_A, ~shadow[2]);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    settle;
    check_all;
    wrap_up;
  end
endmodule : hqr_config_regs_tb

// file: verif/hqr_host_model.sv
/*
  Host side of the register port: issues one-cycle word write and read
  strobes and collects the registered read answer.
  Assumes the bank answers a read with reg_rvalid a few cycles later.
*/
`timescale 1ns/1ps
module hqr_host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end

  // ************************************************************
  // Word write: strobe held across one taking edge
  // ************************************************************
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : write_word

  // ************************************************************
  // Word read: waits a bounded time for the answer
  // ************************************************************
  task automatic read_word(input logic [7:0] a, output logic [15:0] d);
    int i;
    d = 16'hxxxx;
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (i = 0; i < 4; i++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(posedge ref_clk);
    end
  endtask : read_word
endmodule : hqr_host_model

// file: verilog/hqr_config_regs.sv
/*
  Configuration and status register bank of the rotation sensor: event
  mask, quadrature output control and live state, filter coefficients,
  rotation interface settings and interval scaling fields.
  Assumes the I2C slave presents one-cycle word read and write strobes
  in the ref_clk domain, and that core results arrive on ref_clk.
*/
`timescale 1ns/1ps
// Summary of operation
// - Mask bits 0..3 gate power, tuning, touch, proximity events; reset 0x001D.
// - Mask bit 4 gates the interval-change event.
// - Quadrature mode 0 off, 1 open-drain, 2 push-pull; reset 2.
// - Bits 8..10 report the quadrature sequencer state.
// - Bit 12 mirrors second encoder output level.
// - Bit 11 mirrors first encoder output level.
// - Coefficients A: fast in upper byte, slow in lower; reset 0x0205.
// - Coefficients B: auto-zero upper, low-power lower; reset 0x0101.
// - Settings bit 8 enables rotation interface; reset 0x0106.
// - Bit 7 set discards intervals missed while stationary.
// - Bit 6 forces precise rate while freewheeling under auto power.
// - Bit 5 inverts sampled rotation direction.
// - Writing 1 to bit 4 zeroes interval once; bit self-clears.
// - Auto-zero field selects off, stationary, continuous, release.
// - Bit 1 enables Hall measurement; set after reset.
// - Bit 0 enables freewheel interface; clear after reset.
// - Scaling bits 9..13 fine divider; 14..15 reserved; both registers alike.
// - Scaling bits 5..8 coarse multiplier, 0..4 coarse divider.
// - Events pass only while event mode is selected.
module hqr_config_regs #(
  parameter int unsigned NUM_SCALE = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [hqr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [hqr_pkg::DATA_W-1:0] reg_wdata,
  output logic [hqr_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // System settings word
  input wire logic [hqr_pkg::DATA_W-1:0] sys_settings,
  // Core events and status
  input wire logic [hqr_pkg::EV_NUM-1:0] event_raw,
  input wire logic [2:0] quad_state,
  input wire logic enc0_level,
  input wire logic enc1_level,
  input wire logic freewheeling,
  input wire logic auto_power,
  input wire logic stationary,
  input wire logic direction_raw,
  input wire logic interval_missed,
  // Event and control outputs
  output logic [hqr_pkg::EV_NUM-1:0] event_out,
  output logic [1:0] quad_mode,
  output logic quad_enable,
  output logic quad_open_drain,
  output logic [7:0] fast_coeff,
  output logic [7:0] slow_coeff,
  output logic [7:0] auto_zero_coeff,
  output logic [7:0] low_power_coeff,
  output logic rotation_interface_enable,
  output logic discard_missed,
  output logic keep_missed_report,
  output logic force_precise_rate_freewheel,
  output logic direction,
  output logic zero_pulse,
  output logic [1:0] auto_zero_mode,
  output logic az_on_stationary,
  output logic az_continuous,
  output logic az_on_release,
  output logic sensor_enable,
  output logic freewheel_interface_enable,
  output logic [4:0] fine_div [NUM_SCALE],
  output logic [3:0] coarse_mul [NUM_SCALE],
  output logic [4:0] coarse_div [NUM_SCALE],
  output logic stream_mode
);
  import hqr_pkg::*;

  // ************************************************************
  // Address decode
  // ************************************************************
  wire sel_mask = (reg_addr == ADDR_EVENT_MASK);
  wire sel_quad = (reg_addr == ADDR_QUAD_CTRL);
  wire sel_fa = (reg_addr == ADDR_FILT_A);
  wire sel_fb = (reg_addr == ADDR_FILT_B);
  wire sel_rs = (reg_addr == ADDR_ROT_SET);
  wire [NUM_SCALE-1:0] sel_sc;
  wire wr_mask = reg_wr && sel_mask;
  wire wr_quad = reg_wr && sel_quad;
  wire wr_fa = reg_wr && sel_fa;
  wire wr_fb = reg_wr && sel_fb;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [15:0] mask_q;
  logic [15:0] quad_q;
  logic [15:0] fa_q;
  logic [15:0] fb_q;
  logic [15:0] sc_q [NUM_SCALE];
  logic [15:0] rs_q;
  logic [15:0] rs_d;

  hqr_reg_word #(.RESET_VALUE(RST_EVENT_MASK), .WRITE_MASK(WMASK_EVENT_MASK)) u_mask (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .wr_en(wr_mask), .wr_data(reg_wdata), .value_q(mask_q)
  );
  hqr_reg_word #(.RESET_VALUE(RST_QUAD_CTRL), .WRITE_MASK(WMASK_QUAD_CTRL)) u_quad (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .wr_en(wr_quad), .wr_data(reg_wdata), .value_q(quad_q)
  );
  hqr_reg_word #(.RESET_VALUE(RST_FILT_A), .WRITE_MASK(WMASK_FULL)) u_fa (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .wr_en(wr_fa), .wr_data(reg_wdata), .value_q(fa_q)
  );
  hqr_reg_word #(.RESET_VALUE(RST_FILT_B), .WRITE_MASK(WMASK_FULL)) u_fb (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .wr_en(wr_fb), .wr_data(reg_wdata), .value_q(fb_q)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SCALE; gi++) begin : g_sc
      assign sel_sc[gi] = (reg_addr == ADDR_SCALE_A + 8'(gi));
      hqr_reg_word #(.RESET_VALUE(RST_SCALE), .WRITE_MASK(WMASK_SCALE)) u_sc (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .wr_en(reg_wr && sel_sc[gi]),
        .wr_data(reg_wdata), .value_q(sc_q[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Rotation settings with self-clearing zero request
  // ************************************************************
  wire wr_rs = reg_wr && sel_rs;
  wire zero_req = rs_q[RS_ZERO_NOW];
  always_comb begin
    rs_d = rs_q;
    if (zero_req) begin
      rs_d[RS_ZERO_NOW] = 1'b0;
    end
    if (wr_rs) begin
      rs_d = (reg_wdata & WMASK_ROT_SET) | (rs_q & ~WMASK_ROT_SET);
      rs_d[RS_ZERO_NOW] = reg_wdata[RS_ZERO_NOW];
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rs_q <= RST_ROT_SET;
    end else if (clk_en) begin
      rs_q <= rs_d;
    end
  end

  // ************************************************************
  // Status capture and read mux
  // ************************************************************
  logic [2:0] qs_q;
  logic e0_q;
  logic e1_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      qs_q <= 3'h0;
      e0_q <= 1'b0;
      e1_q <= 1'b0;
    end else if (clk_en) begin
      qs_q <= quad_state;
      e0_q <= enc0_level;
      e1_q <= enc1_level;
    end
  end

  logic [15:0] quad_rd;
  logic [15:0] sc_rd;
  logic [15:0] rd_mux;
  always_comb begin
    quad_rd = quad_q & WMASK_QUAD_CTRL;
    quad_rd[QS_MSB:QS_LSB] = qs_q;
    quad_rd[QE0_BIT] = e0_q;
    quad_rd[QE1_BIT] = e1_q;
    sc_rd = 16'h0000;
    for (int i = 0; i < NUM_SCALE; i++) begin
      if (sel_sc[i]) begin
        sc_rd = sc_q[i] & WMASK_SCALE;
      end
    end
  end
  assign rd_mux = sel_mask ? (mask_q & WMASK_EVENT_MASK) :
                  sel_quad ? quad_rd :
                  sel_fa ? fa_q :
                  sel_fb ? fb_q :
                  sel_rs ? (rs_q & WMASK_ROT_SET) :
                  sc_rd;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ************************************************************
  // Decoded controls
  // ************************************************************
  wire event_mode = sys_settings[SYS_EVENT_MODE];
  wire [EV_NUM-1:0] ev_d = event_mode ? (event_raw & mask_q[EV_NUM-1:0]) : {EV_NUM{1'b0}};
  wire [1:0] qm = quad_q[QM_MSB:QM_LSB];
  wire [1:0] az = rs_q[RS_AZ_MSB:RS_AZ_LSB];
  wire force_d = rs_q[RS_FORCE_PRECISE] && freewheeling && auto_power;
  wire discard_d = rs_q[RS_DISCARD] && stationary && interval_missed;
  wire keep_d = !rs_q[RS_DISCARD] && stationary && interval_missed;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_out <= '0;
      quad_mode <= 2'h0;
      quad_enable <= 1'b0;
      quad_open_drain <= 1'b0;
      fast_coeff <= 8'h00;
      slow_coeff <= 8'h00;
      auto_zero_coeff <= 8'h00;
      low_power_coeff <= 8'h00;
      rotation_interface_enable <= 1'b0;
      discard_missed <= 1'b0;
      keep_missed_report <= 1'b0;
      force_precise_rate_freewheel <= 1'b0;
      direction <= 1'b0;
      zero_pulse <= 1'b0;
      auto_zero_mode <= 2'h0;
      az_on_stationary <= 1'b0;
      az_continuous <= 1'b0;
      az_on_release <= 1'b0;
      sensor_enable <= 1'b0;
      freewheel_interface_enable <= 1'b0;
      stream_mode <= 1'b0;
      for (int i = 0; i < NUM_SCALE; i++) begin
        fine_div[i] <= 5'h00;
        coarse_mul[i] <= 4'h0;
        coarse_div[i] <= 5'h00;
      end
    end else if (clk_en) begin
      event_out <= ev_d;
      quad_mode <= qm;
      quad_enable <= (qm == HQR_QM_OPEN_DRAIN) || (qm == HQR_QM_PUSH_PULL);
      quad_open_drain <= (qm == HQR_QM_OPEN_DRAIN);
      fast_coeff <= fa_q[DATA_W-1:BYTE_W];
      slow_coeff <= fa_q[BYTE_W-1:0];
      auto_zero_coeff <= fb_q[DATA_W-1:BYTE_W];
      low_power_coeff <= fb_q[BYTE_W-1:0];
      rotation_interface_enable <= rs_q[RS_UI_EN];
      discard_missed <= discard_d;
      keep_missed_report <= keep_d;
      force_precise_rate_freewheel <= force_d;
      direction <= direction_raw ^ rs_q[RS_REVERSE];
      zero_pulse <= zero_req;
      auto_zero_mode <= az;
      az_on_stationary <= (az == HQR_AZ_STATIONARY);
      az_continuous <= (az == HQR_AZ_CONTINUOUS);
      az_on_release <= (az == HQR_AZ_RELEASE);
      sensor_enable <= rs_q[RS_SENSOR_EN];
      freewheel_interface_enable <= rs_q[RS_FW_EN];
      stream_mode <= !event_mode;
      for (int i = 0; i < NUM_SCALE; i++) begin
        fine_div[i] <= sc_q[i][SC_FDIV_MSB:SC_FDIV_LSB];
        coarse_mul[i] <= sc_q[i][SC_CMUL_MSB:SC_CMUL_LSB];
        coarse_div[i] <= sc_q[i][SC_CDIV_MSB:SC_CDIV_LSB];
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  logic chk_armed_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chk_armed_q <= 1'b0;
    end else if (clk_en) begin
      chk_armed_q <= 1'b1;
    end
  end
  // Checks wait one enabled edge after reset, while outputs still hold reset values
  default disable iff (rst || !chk_armed_q);

  chk_zero_selfclear: assert property (clk_en && wr_rs && reg_wdata[RS_ZERO_NOW] ##1 clk_en |=>
    !rs_q[RS_ZERO_NOW] || $past(wr_rs)) else $error("zero request did not self clear");
  chk_zero_pulse: assert property (clk_en && zero_req |=> zero_pulse)
    else $error("zero pulse missing");
  chk_event_gate: assert property (clk_en |=> event_out == ($past(event_mode) ?
    ($past(event_raw) & $past(mask_q[EV_NUM-1:0])) : 5'h00)) else $error("event gating wrong");
  chk_interval_ev: assert property (clk_en && !mask_q[EV_INTERVAL] |=> !event_out[EV_INTERVAL])
    else $error("interval event leaked");
  chk_stream_mode: assert property (clk_en && !event_mode |=> stream_mode && event_out == 5'h00)
    else $error("stream mode events");
  chk_quad_drive: assert property (clk_en && qm == HQR_QM_OFF |=> !quad_enable)
    else $error("quadrature enabled while off");
  chk_quad_ro: assert property (clk_en && wr_quad |=> quad_q[QS_MSB:QS_LSB] == 3'h0 && quad_q[QE1_BIT] == 1'b0)
    else $error("status bits stored");
  chk_enc_mirror: assert property (clk_en ##1 clk_en && $past(reg_rd) && $past(sel_quad) |->
    reg_rdata[QE1_BIT] == $past(e1_q) && reg_rdata[QE0_BIT] == $past(e0_q)) else $error("encoder mirror wrong");
  chk_rsv_zero: assert property (clk_en && reg_rd && !sel_fa && !sel_fb |=> reg_rdata[15:14] == 2'h0)
    else $error("reserved bits nonzero");
  chk_direction: assert property (clk_en |=> direction == ($past(direction_raw) ^ $past(rs_q[RS_REVERSE])))
    else $error("direction sense wrong");
  chk_force_rate: assert property (clk_en && !rs_q[RS_FORCE_PRECISE] |=> !force_precise_rate_freewheel)
    else $error("precise rate forced");
  chk_force_on: assert property (clk_en && rs_q[RS_FORCE_PRECISE] && freewheeling && auto_power |=>
    force_precise_rate_freewheel) else $error("precise rate not forced");
  chk_open_drain: assert property (clk_en |=> quad_open_drain == ($past(qm) == HQR_QM_OPEN_DRAIN))
    else $error("open drain decode wrong");
  chk_coeff_a: assert property (clk_en |=> {fast_coeff, slow_coeff} == $past(fa_q))
    else $error("coefficients a wrong");
  chk_coeff_b: assert property (clk_en |=> {auto_zero_coeff, low_power_coeff} == $past(fb_q))
    else $error("coefficients b wrong");
  chk_ui_enable: assert property (clk_en |=> rotation_interface_enable == $past(rs_q[RS_UI_EN]))
    else $error("interface enable wrong");
  chk_discard_keep: assert property (clk_en && stationary && interval_missed |=>
    discard_missed == $past(rs_q[RS_DISCARD]) && keep_missed_report == !$past(rs_q[RS_DISCARD]))
    else $error("missed interval policy wrong");
  chk_az_mode: assert property (clk_en |=> auto_zero_mode == $past(az) &&
    $onehot0({az_on_stationary, az_continuous, az_on_release})) else $error("auto zero decode wrong");
  chk_sensor_en: assert property (clk_en |=> sensor_enable == $past(rs_q[RS_SENSOR_EN]))
    else $error("sensor enable wrong");
  chk_fw_enable: assert property (clk_en |=> freewheel_interface_enable == $past(rs_q[RS_FW_EN]))
    else $error("freewheel enable wrong");
  chk_fine_div: assert property (clk_en |=> fine_div[0] == $past(sc_q[0][SC_FDIV_MSB:SC_FDIV_LSB]))
    else $error("fine divider wrong");
  chk_coarse_fields: assert property (clk_en |=> {coarse_mul[0], coarse_div[0]} ==
    $past(sc_q[0][SC_CMUL_MSB:SC_CDIV_LSB])) else $error("coarse fields wrong");
  chk_freeze: assert property (!clk_en |=> $stable(rs_q) && $stable(mask_q) && $stable(reg_rvalid))
    else $error("state moved while frozen");

  cov_zero_now: cover property (wr_rs && reg_wdata[RS_ZERO_NOW] ##[1:3] zero_pulse);
  cov_event: cover property (|event_out);
  cov_open_drain: cover property (quad_open_drain);
  cov_read: cover property (reg_rvalid && $past(sel_rs));
  cov_freeze_write: cover property (!clk_en && wr_fa);
endmodule : hqr_config_regs

// file: verilog/hqr_pkg.sv
/*
  Package for the rotation sensor configuration register bank: register
  word addresses, field positions, reset values and encodings.
  Assumes a 16-bit word register port with 8-bit word addresses.
*/
package hqr_pkg;
  // ************************************************************
  // Widths
  // ************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h67;
  localparam logic [7:0] ADDR_QUAD_CTRL = 8'h69;
  localparam logic [7:0] ADDR_FILT_A = 8'h78;
  localparam logic [7:0] ADDR_FILT_B = 8'h79;
  localparam logic [7:0] ADDR_ROT_SET = 8'h7a;
  localparam logic [7:0] ADDR_SCALE_A = 8'h80;
  localparam logic [7:0] ADDR_SCALE_B = 8'h81;
  localparam logic [7:0] ADDR_SYS_SET = 8'h60;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] RST_EVENT_MASK = 16'h001d;
  localparam logic [15:0] RST_QUAD_CTRL = 16'h0002;
  localparam logic [15:0] RST_FILT_A = 16'h0205;
  localparam logic [15:0] RST_FILT_B = 16'h0101;
  localparam logic [15:0] RST_ROT_SET = 16'h0106;
  localparam logic [15:0] RST_SCALE = 16'h05e2;

  // ************************************************************
  // Writable bit masks
  // ************************************************************
  localparam logic [15:0] WMASK_EVENT_MASK = 16'h001f;
  localparam logic [15:0] WMASK_QUAD_CTRL = 16'h0003;
  localparam logic [15:0] WMASK_ROT_SET = 16'h01ff;
  localparam logic [15:0] WMASK_SCALE = 16'h3fff;
  localparam logic [15:0] WMASK_FULL = 16'hffff;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned EV_POWER = 0;
  localparam int unsigned EV_ATI = 1;
  localparam int unsigned EV_TOUCH = 2;
  localparam int unsigned EV_PROX = 3;
  localparam int unsigned EV_INTERVAL = 4;
  localparam int unsigned EV_NUM = 5;
  localparam int unsigned QM_LSB = 0;
  localparam int unsigned QM_MSB = 1;
  localparam int unsigned QS_LSB = 8;
  localparam int unsigned QS_MSB = 10;
  localparam int unsigned QE0_BIT = 11;
  localparam int unsigned QE1_BIT = 12;
  localparam int unsigned RS_FW_EN = 0;
  localparam int unsigned RS_SENSOR_EN = 1;
  localparam int unsigned RS_AZ_LSB = 2;
  localparam int unsigned RS_AZ_MSB = 3;
  localparam int unsigned RS_ZERO_NOW = 4;
  localparam int unsigned RS_REVERSE = 5;
  localparam int unsigned RS_FORCE_PRECISE = 6;
  localparam int unsigned RS_DISCARD = 7;
  localparam int unsigned RS_UI_EN = 8;
  localparam int unsigned SC_CDIV_LSB = 0;
  localparam int unsigned SC_CDIV_MSB = 4;
  localparam int unsigned SC_CMUL_LSB = 5;
  localparam int unsigned SC_CMUL_MSB = 8;
  localparam int unsigned SC_FDIV_LSB = 9;
  localparam int unsigned SC_FDIV_MSB = 13;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SYS_EVENT_MODE = 13;

  // ************************************************************
  // Encodings
  // ************************************************************
  typedef enum logic [1:0] {
    HQR_QM_OFF = 2'h0,
    HQR_QM_OPEN_DRAIN = 2'h1,
    HQR_QM_PUSH_PULL = 2'h2
  } hqr_quad_mode_type;

  typedef enum logic [2:0] {
    HQR_QS_IDLE_LOW = 3'h0,
    HQR_QS_IDLE_HIGH = 3'h1,
    HQR_QS_FOLLOW_LOW = 3'h2,
    HQR_QS_FOLLOW_HIGH = 3'h3,
    HQR_QS_WAIT_NEXT = 3'h4
  } hqr_quad_state_type;

  typedef enum logic [1:0] {
    HQR_AZ_OFF = 2'h0,
    HQR_AZ_STATIONARY = 2'h1,
    HQR_AZ_CONTINUOUS = 2'h2,
    HQR_AZ_RELEASE = 2'h3
  } hqr_auto_zero_type;
endpackage : hqr_pkg

// file: verilog/hqr_reg_word.sv
/*
  One 16-bit configuration word with a writable-bit mask.
  Assumes a one-cycle write strobe in the ref_clk domain.
*/
`timescale 1ns/1ps
module hqr_reg_word #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK = 16'hffff
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Write port
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // Stored value
  output logic [15:0] value_q
);
  logic [15:0] value_d;

  assign value_d = (wr_data & WRITE_MASK) | (value_q & ~WRITE_MASK);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      value_q <= RESET_VALUE;
    end else if (clk_en && wr_en) begin
      value_q <= value_d;
    end
  end
endmodule : hqr_reg_word
